// ---- common/scm_link_if.sv ----
// Interface: relay and status wires between monitor and flash control
`timescale 1ns/10ps
interface scm_link_if;
  logic start_hold;
  logic flash_release;
  modport monitor (
    output start_hold,
    output flash_release
  );
  modport flasher (
    input start_hold,
    input flash_release
  );
endinterface

// ---- common/scm_pkg.sv ----
// Package: constants and types shared by the monitor and the flash control end
package scm_pkg;
  localparam int CHANNELS = 12;
  localparam int CLK_HZ = 50000000;
  // Tick period in microseconds
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
  // Thresholds in milliseconds
  localparam int START_HOLD_MS = 2500;
  localparam int CONFLICT_MS = 325;
  localparam int MISSING_MS = 850;
  localparam int OVERLAP_MS = 850;
  localparam int TICKS_START = START_HOLD_MS * 1000 / TICK_US;
  localparam int TICKS_CONFLICT = CONFLICT_MS * 1000 / TICK_US;
  localparam int TICKS_MISSING = MISSING_MS * 1000 / TICK_US;
  localparam int TICKS_OVERLAP = OVERLAP_MS * 1000 / TICK_US;
  localparam int CNT_W = 16;
  // Indication bit positions within one channel
  localparam int IND_GREEN = 0;
  localparam int IND_YELLOW = 1;
  localparam int IND_WALK = 2;
  localparam int IND_RED = 3;
  localparam int IND_W = 4;
  typedef logic [IND_W-1:0] scm_ind_t;
  typedef enum logic [1:0] {SCM_START, SCM_FLASH, SCM_RUN} scm_state_t;
endpackage

// ---- src/scm_flash_ctl.sv ----
// Flash control end: gates field outputs by the monitor relays
`timescale 1ns/10ps
module scm_flash_ctl #(
  parameter int CHANNELS = scm_pkg::CHANNELS,
  parameter int FLASH_DIV = 25000000
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  scm_link_if.flasher LINK,
  input wire logic [CHANNELS-1:0] HWY_THRU,
  input wire logic [CHANNELS-1:0] AW_CHAN,
  input wire logic THRU_FLASH_YELLOW,
  input wire logic [CHANNELS*scm_pkg::IND_W-1:0] CU_IND,
  output logic [CHANNELS*scm_pkg::IND_W-1:0] FIELD_IND,
  output logic CU_RESET,
  output logic IN_FLASH
);
  logic [1:0] rel_sync;
  logic [1:0] hold_sync;
  logic [31:0] div_cnt;
  logic [31:0] next_div_cnt;
  logic phase;
  logic next_phase;
  logic [CHANNELS*scm_pkg::IND_W-1:0] next_field;
  logic next_flash;

  // ***************************************************************
  // Flash timing
  // ***************************************************************
  always_comb begin
    next_div_cnt = div_cnt + 32'h1;
    next_phase = phase;
    if (div_cnt == 32'(FLASH_DIV - 1)) begin
      next_div_cnt = 32'h0;
      next_phase = ~phase;
    end
    // Relay levels come from another device, so they pass a synchroniser
    next_flash = ~rel_sync[1];
  end

  // ***************************************************************
  // Field output gating
  // ***************************************************************
  always_comb begin
    next_field = CU_IND;
    for (int c = 0; c < CHANNELS; c++) begin
      if (IN_FLASH && !AW_CHAN[c]) begin
        next_field[c*scm_pkg::IND_W +: scm_pkg::IND_W] = '0;
        if (HWY_THRU[c] && THRU_FLASH_YELLOW) begin
          next_field[c*scm_pkg::IND_W + scm_pkg::IND_YELLOW] = phase;
        end else begin
          next_field[c*scm_pkg::IND_W + scm_pkg::IND_RED] = phase;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rel_sync <= 2'h0;
      hold_sync <= 2'h3;
      div_cnt <= 32'h0;
      phase <= 1'b0;
      FIELD_IND <= '0;
      IN_FLASH <= 1'b1;
      CU_RESET <= 1'b1;
    end else begin
      rel_sync <= {rel_sync[0], LINK.flash_release};
      hold_sync <= {hold_sync[0], LINK.start_hold};
      div_cnt <= next_div_cnt;
      phase <= next_phase;
      FIELD_IND <= next_field;
      IN_FLASH <= next_flash;
      // Controller keeps running in flash; only the startup reset stops it
      CU_RESET <= hold_sync[1];
    end
  end
endmodule

// ---- src/scm_monitor.sv ----
// Monitor end: conflict, overlap and missing-indication detection
`timescale 1ns/10ps
// Summary of operation
// - Twelve channels, four indications each
// - Incompatible non-red indications on two channels conflict
// - Two indications together on one channel overlap
// - No indication on a channel is missing
// - Drive startup hold and flash release relays
// - Hold system reset 2.5 s after power up
// - Flash after power up and on faults
// - Highway through flashes yellow or red
// - Left turns and cross streets flash red
// - Advance warning keeps running in flash
// - Controller keeps cycling phases in flash
// - Flash control blocks controller colour outputs
// - Leave flash only when monitor says safe
// - Conflict qualifies after 325 ms
// - Missing indication qualifies after 850 ms
// - Latch faults until manual reset
// - Compatible channel pairs never conflict
module scm_monitor #(
  parameter int CHANNELS = scm_pkg::CHANNELS,
  parameter int TICK_CYCLES = scm_pkg::TICK_CYCLES,
  parameter int TICKS_START = scm_pkg::TICKS_START,
  parameter int TICKS_CONFLICT = scm_pkg::TICKS_CONFLICT,
  parameter int TICKS_MISSING = scm_pkg::TICKS_MISSING,
  parameter int TICKS_OVERLAP = scm_pkg::TICKS_OVERLAP
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  scm_link_if.monitor LINK,
  input wire logic [CHANNELS*scm_pkg::IND_W-1:0] FIELD_IN,
  input wire logic [CHANNELS*CHANNELS-1:0] COMPAT,
  input wire logic MAN_RESET,
  output logic [CHANNELS-1:0] CONFLICT_FAULT,
  output logic [CHANNELS-1:0] OVERLAP_FAULT,
  output logic [CHANNELS-1:0] MISSING_FAULT,
  output logic FAULT
);
  localparam int CW = scm_pkg::CNT_W;

  logic [CHANNELS*scm_pkg::IND_W-1:0] in_s1;
  logic [CHANNELS*scm_pkg::IND_W-1:0] in_s2;
  logic [1:0] mr_sync;
  logic [31:0] div_cnt;
  logic [31:0] next_div_cnt;
  logic tick;
  logic next_tick;
  scm_pkg::scm_state_t state;
  scm_pkg::scm_state_t next_state;
  logic [CW-1:0] start_cnt;
  logic [CW-1:0] next_start_cnt;
  logic [CW-1:0] conf_cnt [CHANNELS];
  logic [CW-1:0] next_conf_cnt [CHANNELS];
  logic [CW-1:0] ovl_cnt [CHANNELS];
  logic [CW-1:0] next_ovl_cnt [CHANNELS];
  logic [CW-1:0] miss_cnt [CHANNELS];
  logic [CW-1:0] next_miss_cnt [CHANNELS];
  logic [CHANNELS-1:0] conf_raw;
  logic [CHANNELS-1:0] ovl_raw;
  logic [CHANNELS-1:0] miss_raw;
  logic [CHANNELS-1:0] next_conf_f;
  logic [CHANNELS-1:0] next_ovl_f;
  logic [CHANNELS-1:0] next_miss_f;
  logic next_fault;
  logic next_hold;
  logic next_release;

  function automatic scm_pkg::scm_ind_t chan_ind(
    input logic [CHANNELS*scm_pkg::IND_W-1:0] v, input int c);
    chan_ind = v[c*scm_pkg::IND_W +: scm_pkg::IND_W];
  endfunction

  // Green, yellow or walk lit; red never conflicts
  function automatic logic go_lit(input scm_pkg::scm_ind_t i);
    go_lit = i[scm_pkg::IND_GREEN] | i[scm_pkg::IND_YELLOW] |
      i[scm_pkg::IND_WALK];
  endfunction

  // Advance a qualification timer; restarts when the cause goes away
  function automatic logic [CW-1:0] qual(input logic cond,
    input logic [CW-1:0] cnt, input logic tk, input int lim);
    if (!cond) begin
      qual = '0;
    end else if (tk && cnt < CW'(lim)) begin
      qual = cnt + CW'(1);
    end else begin
      qual = cnt;
    end
  endfunction

  // ***************************************************************
  // Tick divider and startup sequence
  // ***************************************************************
  always_comb begin
    next_div_cnt = div_cnt + 32'h1;
    next_tick = 1'b0;
    if (div_cnt == 32'(TICK_CYCLES - 1)) begin
      next_div_cnt = 32'h0;
      next_tick = 1'b1;
    end
    next_state = state;
    next_start_cnt = start_cnt;
    case (state)
      scm_pkg::SCM_START: begin
        if (tick) begin
          next_start_cnt = start_cnt + CW'(1);
        end
        if (start_cnt >= CW'(TICKS_START)) begin
          next_state = scm_pkg::SCM_FLASH;
        end
      end
      scm_pkg::SCM_FLASH: begin
        if (!next_fault) begin
          next_state = scm_pkg::SCM_RUN;
        end
      end
      scm_pkg::SCM_RUN: begin
        if (next_fault) begin
          next_state = scm_pkg::SCM_FLASH;
        end
      end
      default: next_state = scm_pkg::SCM_START;
    endcase
    next_hold = (next_state == scm_pkg::SCM_START);
    next_release = (next_state == scm_pkg::SCM_RUN);
  end

  // ***************************************************************
  // Fault detection
  // ***************************************************************
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      scm_pkg::scm_ind_t ic;
      ic = chan_ind(in_s2, c);
      conf_raw[c] = 1'b0;
      for (int d = 0; d < CHANNELS; d++) begin
        if (d != c && go_lit(ic) && go_lit(chan_ind(in_s2, d)) &&
            !COMPAT[c*CHANNELS + d] && !COMPAT[d*CHANNELS + c]) begin
          conf_raw[c] = 1'b1;
        end
      end
      ovl_raw[c] = ($countones(ic) > 1);
      miss_raw[c] = (ic == '0);
      next_conf_cnt[c] = qual(conf_raw[c], conf_cnt[c], tick,
        TICKS_CONFLICT);
      next_ovl_cnt[c] = qual(ovl_raw[c], ovl_cnt[c], tick, TICKS_OVERLAP);
      next_miss_cnt[c] = qual(miss_raw[c], miss_cnt[c], tick,
        TICKS_MISSING);
      // Latched; only manual reset clears, and a live fault wins over it
      next_conf_f[c] = (conf_cnt[c] >= CW'(TICKS_CONFLICT)) ||
        (CONFLICT_FAULT[c] && !mr_sync[1]);
      next_ovl_f[c] = (ovl_cnt[c] >= CW'(TICKS_OVERLAP)) ||
        (OVERLAP_FAULT[c] && !mr_sync[1]);
      next_miss_f[c] = (miss_cnt[c] >= CW'(TICKS_MISSING)) ||
        (MISSING_FAULT[c] && !mr_sync[1]);
    end
    next_fault = |{next_conf_f, next_ovl_f, next_miss_f};
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      in_s1 <= '0;
      in_s2 <= '0;
      mr_sync <= 2'h0;
      div_cnt <= 32'h0;
      tick <= 1'b0;
      state <= scm_pkg::SCM_START;
      start_cnt <= '0;
      for (int c = 0; c < CHANNELS; c++) begin
        conf_cnt[c] <= '0;
        ovl_cnt[c] <= '0;
        miss_cnt[c] <= '0;
      end
      CONFLICT_FAULT <= '0;
      OVERLAP_FAULT <= '0;
      MISSING_FAULT <= '0;
      FAULT <= 1'b0;
      LINK.start_hold <= 1'b1;
      LINK.flash_release <= 1'b0;
    end else begin
      in_s1 <= FIELD_IN;
      in_s2 <= in_s1;
      mr_sync <= {mr_sync[0], MAN_RESET};
      div_cnt <= next_div_cnt;
      tick <= next_tick;
      state <= next_state;
      start_cnt <= next_start_cnt;
      conf_cnt <= next_conf_cnt;
      ovl_cnt <= next_ovl_cnt;
      miss_cnt <= next_miss_cnt;
      CONFLICT_FAULT <= next_conf_f;
      OVERLAP_FAULT <= next_ovl_f;
      MISSING_FAULT <= next_miss_f;
      FAULT <= next_fault;
      LINK.start_hold <= next_hold;
      LINK.flash_release <= next_release;
    end
  end
endmodule

// ---- tb/scm_link_props.sv ----
// Checker: relay and flash relations across the monitor link
`timescale 1ns/10ps
module scm_link_props #(
  parameter int TICK_CYCLES = 10,
  parameter int TICKS_START = 5
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire logic start_hold,
  input wire logic flash_release,
  input wire logic FAULT,
  input wire logic MAN_RESET,
  input wire logic IN_FLASH,
  input wire logic CU_RESET
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  logic [15:0] hold_cnt;
  // Saturating count of startup hold cycles since reset
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) hold_cnt <= 16'h0000;
    else if (start_hold && hold_cnt != 16'hffff) hold_cnt <= hold_cnt + 1'b1;
  end
  property p_hold_len;
    $fell(start_hold) |-> hold_cnt >= (TICKS_START - 1) * TICK_CYCLES
      && hold_cnt <= (TICKS_START + 1) * TICK_CYCLES + 3;
  endproperty
  a_hold_len: assert property (p_hold_len)
    else $error("startup hold length off");
  property p_hold_once;
    !start_hold |=> !start_hold;
  endproperty
  a_hold_once: assert property (p_hold_once)
    else $error("startup hold came back");
  property p_hold_no_rel;
    start_hold |-> !flash_release;
  endproperty
  a_hold_no_rel: assert property (p_hold_no_rel)
    else $error("release during startup");
  property p_rel_no_fault;
    FAULT |-> !flash_release;
  endproperty
  a_rel_no_fault: assert property (p_rel_no_fault)
    else $error("release with fault");
  property p_rel_after_hold;
    $fell(start_hold) && !FAULT |-> ##[1:2] flash_release;
  endproperty
  a_rel_after_hold: assert property (p_rel_after_hold)
    else $error("no release after startup");
  property p_cu_reset;
    $fell(start_hold) |-> CU_RESET ##[1:4] !CU_RESET;
  endproperty
  a_cu_reset: assert property (p_cu_reset)
    else $error("controller reset not released");
  property p_in_flash;
    !flash_release [*6] |-> IN_FLASH;
  endproperty
  a_in_flash: assert property (p_in_flash)
    else $error("not in flash without release");
  property p_fault_latch;
    $fell(FAULT) |-> $past(MAN_RESET, 2);
  endproperty
  a_fault_latch: assert property (p_fault_latch)
    else $error("fault cleared without manual reset");
endmodule

// ---- tb/signal_conflict_monitor_bench.sv ----
// Testbench: both ends joined, faults driven at the field inputs
`timescale 1ns/10ps
module signal_conflict_monitor_bench;
  localparam logic [47:0] RED = 48'h888888888888;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [47:0] field_in = RED;
  logic [143:0] compat = 144'h0;
  logic man_reset = 1'b0;
  logic [47:0] cu_ind = 48'h111111111111;
  logic [47:0] field_ind;
  logic [11:0] conflict_fault, overlap_fault, missing_fault;
  logic fault, cu_reset, in_flash;
  int n_errors = 0;
  int n_compared = 0;
  int n;
  logic lit;
  logic dark;
  logic [11:0] hwy_thru = 12'h001;
  logic [11:0] aw_chan = 12'h800;
  logic thru_yellow = 1'b1;
  // Short ticks keep the run brief; all bounds below derive from them
  localparam int TB_TICK = 10;
  localparam int TB_START = 5;
  localparam int TB_CONF = 3;
  localparam int TB_LONG = 8;
  localparam int TB_FLASH_DIV = 4;
  scm_link_if link_inst ();
  scm_monitor #(.TICK_CYCLES(TB_TICK), .TICKS_START(TB_START),
    .TICKS_CONFLICT(TB_CONF), .TICKS_MISSING(TB_LONG),
    .TICKS_OVERLAP(TB_LONG)) scm_monitor_inst (
    .CORE_CLK(core_clk), .RST_B(rst_b), .LINK(link_inst.monitor),
    .FIELD_IN(field_in), .COMPAT(compat), .MAN_RESET(man_reset),
    .CONFLICT_FAULT(conflict_fault), .OVERLAP_FAULT(overlap_fault),
    .MISSING_FAULT(missing_fault), .FAULT(fault));
  scm_flash_ctl #(.FLASH_DIV(TB_FLASH_DIV)) scm_flash_ctl_inst (
    .CORE_CLK(core_clk), .RST_B(rst_b), .LINK(link_inst.flasher),
    .HWY_THRU(hwy_thru), .AW_CHAN(aw_chan),
    .THRU_FLASH_YELLOW(thru_yellow),
    .CU_IND(cu_ind), .FIELD_IND(field_ind), .CU_RESET(cu_reset),
    .IN_FLASH(in_flash));
  scm_link_props #(.TICK_CYCLES(TB_TICK), .TICKS_START(TB_START))
    scm_link_props_inst (
    .CORE_CLK(core_clk), .RST_B(rst_b),
    .start_hold(link_inst.start_hold),
    .flash_release(link_inst.flash_release), .FAULT(fault),
    .MAN_RESET(man_reset), .IN_FLASH(in_flash), .CU_RESET(cu_reset));
  always #10 core_clk = ~core_clk;
  task automatic check(input string what, input logic [47:0] seen,
      input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Drives a field pattern and counts cycles until a fault shows
  task automatic write_wait(input logic [47:0] v, output int c);
    field_in = v;
    c = 0;
    while (fault !== 1'b1 && c < 200) begin
      step(1);
      c++;
    end
    if (fault !== 1'b1) begin
      n_errors++;
      end_sim;
    end
  endtask
  task automatic clear(input string t);
    field_in = RED;
    step(4);
    man_reset = 1'b1;
    step(8);
    man_reset = 1'b0;
    step(4);
    check("fault", fault, 1'b0);
    check("release", link_inst.flash_release, 1'b1);
    $display("end of test %s", t);
  endtask
  initial begin
    step(6);
    rst_b = 1'b1;
    step(2);
    check("hold", link_inst.start_hold, 1'b1);
    check("cu reset", cu_reset, 1'b1);
    check("in flash", in_flash, 1'b1);
    check("no colour", field_ind & 48'h077777777770, 48'h0);
    check("aw", field_ind[47:44], 4'h1);
    check("thru", field_ind[3:0] & 4'hd, 4'h0);
    n = 0;
    while (link_inst.start_hold === 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    check("hold len", n >= 36 && n <= 62, 1'b1);
    if (n >= 100) begin
      end_sim;
    end
    step(8);
    check("release", link_inst.flash_release, 1'b1);
    check("field", field_ind, cu_ind);
    check("cu run", cu_reset, 1'b0);
    $display("end of test startup");
    repeat (4) begin
      field_in = 48'h888888888811;
      step(12);
      field_in = RED;
      step(4);
    end
    check("short", fault, 1'b0);
    $display("end of test short");
    write_wait(48'h888888888811, n);
    check("conf time", n >= 18 && n <= 45, 1'b1);
    check("conf", conflict_fault, 12'h003);
    check("release", link_inst.flash_release, 1'b0);
    field_in = RED;
    step(50);
    check("latch", conflict_fault, 12'h003);
    check("flash", in_flash, 1'b1);
    // Through channel switched to red flash while the fault holds flash
    thru_yellow = 1'b0;
    step(2);
    check("thru red", field_ind[3:0] & 4'h7, 4'h0);
    lit = 1'b0;
    dark = 1'b0;
    repeat (8) begin
      step(1);
      lit = lit | field_ind[3];
      dark = dark | !field_ind[3];
    end
    check("thru flashing", {lit, dark}, 2'h3);
    thru_yellow = 1'b1;
    clear("conflict");
    compat = 144'h2;
    field_in = 48'h888888888811;
    step(60);
    check("compat", fault, 1'b0);
    $display("end of test compat");
    compat = 144'h0;
    field_in = RED;
    step(4);
    write_wait(48'h888888888988, n);
    check("ovl time", n >= 65 && n <= 95, 1'b1);
    check("ovl", overlap_fault, 12'h004);
    clear("overlap");
    write_wait(48'h888888880888, n);
    check("miss time", n >= 65 && n <= 95, 1'b1);
    check("miss", missing_fault, 12'h008);
    clear("missing");
    end_sim;
  end
endmodule
